//--- design/dsc_defines.svh
// constants for the ddr read strobe capture block
// assumes inclusion by bare name from the package and the module
`ifndef DSC_DEFINES_SVH
`define DSC_DEFINES_SVH

// register byte offsets on apb
`define DSC_OFF_CTRL    12'h000
`define DSC_OFF_STATUS  12'h004
`define DSC_OFF_EQ      12'h008
`define DSC_OFF_BURST   12'h00C

// ctrl field positions
`define DSC_CTRL_EN     0
`define DSC_CTRL_DIFF   1
`define DSC_CTRL_POVEN  2
`define DSC_CTRL_POVAL  3
`define DSC_CTRL_LATLO  4
`define DSC_CTRL_LATHI  5
`define DSC_CTRL_GEAR   6

// status field positions
`define DSC_ST_STLO     0
`define DSC_ST_STHI     1
`define DSC_ST_POL      2
`define DSC_ST_OVF      3
`define DSC_ST_CNTLO    8
`define DSC_ST_CNTHI    15

// widths and reset values
`define DSC_GROUP_W     12
`define DSC_DQ_W        10
`define DSC_WORD_W      20
`define DSC_EQ_W        24
`define DSC_BURST_RST   4'h4
`define DSC_EQ_RST      24'h000000
`define DSC_SYNC_N      3

`endif

//--- design/dsc_pkg.sv
// types shared by the ddr read strobe capture block
// assumes dsc_defines.svh is on the include path
`include "dsc_defines.svh"

package dsc_pkg;

    // read sequencing states
    typedef enum logic [1:0] {
        DSC_IDLE  = 2'b00,
        DSC_ARMED = 2'b01,
        DSC_PRE   = 2'b10,
        DSC_BURST = 2'b11
    } dsc_state_t;

    // software controls
    typedef struct packed {
        logic                   en;
        logic                   diff;
        logic                   pov_en;
        logic                   pov_val;
        logic [1:0]             lat;
        logic                   gear_req;
        logic [3:0]             burst_len;
        logic [`DSC_EQ_W-1:0]   eq;
    } dsc_ctrl_t;

    // whole state of the capture module
    typedef struct packed {
        dsc_state_t                          state;
        dsc_ctrl_t                           ctrl;
        logic [`DSC_SYNC_N-1:0]              s_sync;
        logic [`DSC_SYNC_N-1:0][`DSC_DQ_W-1:0] d_sync;
        logic                                strobe_f;
        logic                                phase;
        logic                                pol;
        logic [`DSC_DQ_W-1:0]                beat0;
        logic [`DSC_WORD_W-1:0]              cap_word;
        logic                                cap_v;
        logic [1:0]                          lat_cnt;
        logic [3:0]                          words;
        logic [1:0][`DSC_WORD_W-1:0]         mem;
        logic                                wp;
        logic                                rp;
        logic [1:0]                          cnt;
        logic                                ovf;
        logic [7:0]                          reads;
        logic [31:0]                         prdata;
    } dsc_st_t;

endpackage

//--- design/dsc_capture.sv
// read strobe capture for one twelve-cell io_cell_group, apb control
// assumes strobe and data pins arrive asynchronous to pclk and that a
// memory controller pulses read_arm on pclk before each read burst
//
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "dsc_defines.svh"

module dsc_capture
    import dsc_pkg::*;
#(
    parameter int EDGE  = 0,   // 0 left, 1 right, 2 top, 3 bottom
    parameter int DEPTH = 2
) (
    // clock and reset
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    // apb slave
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [11:0]              paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    // memory pins, read direction only
    input  wire logic                     strobe_true,
    input  wire logic                     strobe_comp,
    input  wire logic [`DSC_DQ_W-1:0]     dq_in,
    // controller side
    input  wire logic                     read_arm,
    output logic      [`DSC_WORD_W-1:0]   rd_data,
    output logic                          rd_valid,
    input  wire logic                     rd_ready,
    // leveling and buffer settings
    output logic                          capture_clock_polarity,
    output logic      [1:0]               capture_latency_select,
    output logic      [`DSC_GROUP_W*2-1:0] eq_setting,
    output logic                          out_gearing_en
);

    localparam logic [1:0] TOP_E    = 2'h2;
    localparam logic [1:0] BOTTOM_E = 2'h3;
    localparam logic [1:0] EDGE_L   = 2'(EDGE);
    localparam logic [1:0] FULL_N   = 2'(DEPTH);

    // reset image; strobe stages start at the terminated idle level so
    // that leaving reset shows no false strobe edge
    localparam dsc_ctrl_t CTRL_RST = '{
        burst_len: `DSC_BURST_RST,
        eq:        `DSC_EQ_RST,
        default:   '0
    };
    localparam dsc_st_t ST_RST = '{
        state:    DSC_IDLE,
        ctrl:     CTRL_RST,
        s_sync:   '1,
        strobe_f: 1'b1,
        default:  '0
    };

    dsc_st_t r_reg;
    dsc_st_t r_next;

    logic strobe_raw;
    logic apb_wr;
    logic apb_setup;
    logic rise;
    logic fall;
    logic push;
    logic pop;
    logic group_ok;

    // differential strobe uses the pair, single ended the true pin
    assign strobe_raw = r_reg.ctrl.diff ? (strobe_true & ~strobe_comp)
                                        : strobe_true;
    assign apb_wr    = psel & penable & pwrite;
    assign apb_setup = psel & ~penable;
    // bottom edge groups never leave idle
    assign group_ok  = (EDGE_L != BOTTOM_E) & r_reg.ctrl.en;
    // edges of the filtered strobe
    assign rise = (r_reg.s_sync[1] == r_reg.s_sync[2]) &
                  r_reg.s_sync[2] & ~r_reg.strobe_f;
    assign fall = (r_reg.s_sync[1] == r_reg.s_sync[2]) &
                  ~r_reg.s_sync[2] & r_reg.strobe_f;
    // word leaves the latency stage on the chosen phase
    assign push = r_reg.cap_v & (r_reg.lat_cnt == 2'h0) &
                  (r_reg.phase == r_reg.pol);
    assign pop  = rd_valid & rd_ready;

    // handshake and settings outputs
    assign pready                 = 1'b1;
    assign pslverr                = psel & penable &
                                    (paddr != `DSC_OFF_CTRL) &
                                    (paddr != `DSC_OFF_STATUS) &
                                    (paddr != `DSC_OFF_EQ) &
                                    (paddr != `DSC_OFF_BURST);
    assign prdata                 = r_reg.prdata;
    assign rd_valid               = (r_reg.cnt != 2'h0);
    assign rd_data                = r_reg.mem[r_reg.rp];
    assign capture_clock_polarity = r_reg.pol;
    assign capture_latency_select = r_reg.ctrl.lat;
    // top edge lacks output gearing
    assign out_gearing_en = r_reg.ctrl.gear_req & (EDGE_L != TOP_E);

    // per cell equalization, complement cells zero when differential
    genvar gi;
    generate
        for (gi = 0; gi < `DSC_GROUP_W; gi++) begin : g_eq
            if (gi % 2 == 1) begin : g_comp
                assign eq_setting[gi*2 +: 2] = r_reg.ctrl.diff ? 2'h0
                    : r_reg.ctrl.eq[gi*2 +: 2];
            end else begin : g_true
                assign eq_setting[gi*2 +: 2] =
                    r_reg.ctrl.eq[gi*2 +: 2];
            end
        end
    endgenerate

    // next state
    always_comb begin
        r_next = r_reg;
        // three stage pin synchronisers
        r_next.s_sync = {r_reg.s_sync[1:0], strobe_raw};
        r_next.d_sync = {r_reg.d_sync[1:0], dq_in};
        if (r_reg.s_sync[1] == r_reg.s_sync[2]) begin
            r_next.strobe_f = r_reg.s_sync[2];
        end
        r_next.phase = ~r_reg.phase;

        // read sequencing
        unique case (r_reg.state)
            DSC_IDLE: begin
                if (read_arm & group_ok) begin
                    r_next.state = DSC_ARMED;
                end
            end
            DSC_ARMED: begin
                // memory pulls the strobe low for the preamble
                if (~r_reg.strobe_f | fall) begin
                    r_next.state = DSC_PRE;
                end
            end
            DSC_PRE: begin
                if (rise) begin
                    // polarity chosen fresh for this read
                    r_next.pol   = r_reg.ctrl.pov_en ? r_reg.ctrl.pov_val
                                                     : r_reg.phase;
                    r_next.beat0 = r_reg.d_sync[2];
                    r_next.words = 4'h0;
                    r_next.state = DSC_BURST;
                end
            end
            DSC_BURST: begin
                // pol untouched until the next preamble
                if (rise) begin
                    r_next.beat0 = r_reg.d_sync[2];
                end
                if (fall) begin
                    r_next.cap_word = {r_reg.d_sync[2], r_reg.beat0};
                    r_next.cap_v    = 1'b1;
                    r_next.lat_cnt  = r_reg.ctrl.lat;
                    r_next.words    = r_reg.words + 4'h1;
                    if (r_reg.words + 4'h1 >= r_reg.ctrl.burst_len) begin
                        r_next.state = DSC_IDLE;
                        r_next.reads = r_reg.reads + 8'h01;
                    end
                end
            end
        endcase
        if (~group_ok) begin
            r_next.state = DSC_IDLE;
        end

        // latency stage, then sync register into the buffer
        if (r_reg.cap_v & (r_reg.lat_cnt != 2'h0)) begin
            r_next.lat_cnt = r_reg.lat_cnt - 2'h1;
        end
        if (push) begin
            r_next.cap_v = 1'b0;
            if (r_reg.cnt != FULL_N) begin
                r_next.mem[r_reg.wp] = r_reg.cap_word;
                r_next.wp            = ~r_reg.wp;
            end else begin
                // memory cannot be stalled, so a full buffer drops
                r_next.ovf = 1'b1;
            end
        end
        if (pop) begin
            r_next.rp = ~r_reg.rp;
        end
        r_next.cnt = r_reg.cnt + {1'b0, push & (r_reg.cnt != FULL_N)}
                   - {1'b0, pop};

        // apb writes take effect at the access edge
        if (apb_wr) begin
            unique case (paddr)
                `DSC_OFF_CTRL: begin
                    r_next.ctrl.en       = pwdata[`DSC_CTRL_EN];
                    r_next.ctrl.diff     = pwdata[`DSC_CTRL_DIFF];
                    r_next.ctrl.pov_en   = pwdata[`DSC_CTRL_POVEN];
                    r_next.ctrl.pov_val  = pwdata[`DSC_CTRL_POVAL];
                    r_next.ctrl.lat      =
                        pwdata[`DSC_CTRL_LATHI:`DSC_CTRL_LATLO];
                    r_next.ctrl.gear_req = pwdata[`DSC_CTRL_GEAR];
                end
                `DSC_OFF_STATUS: begin
                    // write one clears, a new overflow wins
                    if (pwdata[`DSC_ST_OVF] & ~(push & (r_reg.cnt == FULL_N)))
                    begin
                        r_next.ovf = 1'b0;
                    end
                end
                `DSC_OFF_EQ: begin
                    r_next.ctrl.eq = pwdata[`DSC_EQ_W-1:0];
                end
                `DSC_OFF_BURST: begin
                    r_next.ctrl.burst_len = pwdata[3:0];
                end
                default: begin
                end
            endcase
        end

        // read data latched in the setup cycle
        if (apb_setup & ~pwrite) begin
            unique case (paddr)
                `DSC_OFF_CTRL: begin
                    r_next.prdata = {25'h0000000, r_reg.ctrl.gear_req,
                                     r_reg.ctrl.lat, r_reg.ctrl.pov_val,
                                     r_reg.ctrl.pov_en, r_reg.ctrl.diff,
                                     r_reg.ctrl.en};
                end
                `DSC_OFF_STATUS: begin
                    r_next.prdata = {16'h0000, r_reg.reads, 4'h0,
                                     r_reg.ovf, r_reg.pol, r_reg.state};
                end
                `DSC_OFF_EQ: begin
                    r_next.prdata = {8'h00, r_reg.ctrl.eq};
                end
                `DSC_OFF_BURST: begin
                    r_next.prdata = {28'h0000000, r_reg.ctrl.burst_len};
                end
                default: begin
                    r_next.prdata = 32'h00000000;
                end
            endcase
        end
    end

    // state register, equalization resets to level zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= ST_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    // assertions; the edge checks only bite in top and bottom copies
    a_bottom_idle: assert property (
        @(posedge pclk) disable iff (!presetn)
        (EDGE_L == BOTTOM_E) |-> r_reg.state == DSC_IDLE)
        else $error("bottom edge group left idle");
    a_top_nogear: assert property (
        @(posedge pclk) disable iff (!presetn)
        (EDGE_L == TOP_E) |-> !out_gearing_en)
        else $error("top edge gearing enabled");
    a_pol_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        (r_reg.state == DSC_BURST && $past(r_reg.state) == DSC_BURST)
        |-> $stable(r_reg.pol))
        else $error("polarity changed inside burst");
    a_pol_stand: assert property (
        @(posedge pclk) disable iff (!presetn)
        !(r_reg.state == DSC_PRE && rise)
        |=> $stable(r_reg.pol))
        else $error("polarity moved outside first rise");
    a_pol_pick: assert property (
        @(posedge pclk) disable iff (!presetn)
        (r_reg.state == DSC_PRE && rise && !r_reg.ctrl.pov_en)
        |=> r_reg.pol == $past(r_reg.phase))
        else $error("polarity not taken from first rise");
    a_pre_entry: assert property (
        @(posedge pclk) disable iff (!presetn)
        (r_reg.state == DSC_ARMED && !r_reg.strobe_f && group_ok)
        |=> r_reg.state == DSC_PRE)
        else $error("preamble not seen after arming");
    a_push_phase: assert property (
        @(posedge pclk) disable iff (!presetn)
        (push && r_reg.cnt == 2'h0) |=> rd_valid
        && rd_data == $past(r_reg.cap_word))
        else $error("captured word not loaded");
    // only the two cycle setting is checked; lower settings push sooner
    a_latency: assert property (
        @(posedge pclk) disable iff (!presetn)
        (fall && r_reg.state == DSC_BURST && r_reg.ctrl.lat == 2'h2)
        |=> !push [*2])
        else $error("word pushed before latency stage");
    a_word_pair: assert property (
        @(posedge pclk) disable iff (!presetn)
        (r_reg.state == DSC_BURST && fall)
        |=> r_reg.cap_word == {$past(r_reg.d_sync[2]), $past(r_reg.beat0)})
        else $error("word not built from both beats");
    a_eq_comp: assert property (
        @(posedge pclk) disable iff (!presetn)
        r_reg.ctrl.diff |-> eq_setting[3:2] == 2'h0
        && eq_setting[1:0] == r_reg.ctrl.eq[1:0])
        else $error("complement equalization active");
    a_eq_true: assert property (
        @(posedge pclk) disable iff (!presetn)
        !r_reg.ctrl.diff |-> eq_setting == r_reg.ctrl.eq)
        else $error("single ended equalization altered");
    a_eq_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        (apb_wr && paddr == `DSC_OFF_EQ) |=>
        r_reg.ctrl.eq == $past(pwdata[`DSC_EQ_W-1:0]))
        else $error("equalization write lost");
    a_beat_take: assert property (
        @(posedge pclk) disable iff (!presetn)
        (r_reg.state == DSC_BURST && rise)
        |=> r_reg.beat0 == $past(r_reg.d_sync[2]))
        else $error("rising beat not captured");
    a_no_overfill: assert property (
        @(posedge pclk) disable iff (!presetn)
        r_reg.cnt <= FULL_N)
        else $error("buffer count beyond depth");

    // covers
    c_lat2: cover property (@(posedge pclk) disable iff (!presetn)
        fall && r_reg.state == DSC_BURST && r_reg.ctrl.lat == 2'h2);
    c_burst: cover property (@(posedge pclk) disable iff (!presetn)
        r_reg.state == DSC_BURST ##1 r_reg.state == DSC_IDLE);
    c_full: cover property (@(posedge pclk) disable iff (!presetn)
        r_reg.cnt == FULL_N);
    c_pol1: cover property (@(posedge pclk) disable iff (!presetn)
        r_reg.state == DSC_BURST && r_reg.pol);
    c_ovf: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(r_reg.ovf));

endmodule

`default_nettype wire

//--- verif/dsc_mem_model.sv
// memory side model: drives the strobe pair and data pins for reads
// assumes the bench arms the capture block before calling burst()
`timescale 1ns/1ns
`default_nettype none
`include "dsc_defines.svh"
module dsc_mem_model (
    // memory pins toward the capture block
    output var logic                 strobe_true,
    output var logic                 strobe_comp,
    output var logic [`DSC_DQ_W-1:0] dq_in
);
    logic busy = 1'b0;

    // termination holds the idle strobe; released data lines wander
    initial begin
        strobe_true = 1'b1;
        strobe_comp = 1'b0;
        dq_in = 10'h155;
        #13;
        forever #40 if (!busy) dq_in = ~dq_in;
    end

    // one read: gap, low preamble, then n rise/fall pairs, 320 ns each
    task automatic burst(input int n, input logic [9:0] base, input int gap);
        busy = 1'b1;
        #(7 + gap);
        dq_in = ~base;
        strobe_true = 1'b0;
        strobe_comp = 1'b1;
        #320;
        for (int i = 0; i < n; i++) begin
            dq_in = base + 10'(2 * i);
            #80 strobe_true = 1'b1;
            strobe_comp = 1'b0;
            #80 dq_in = base + 10'(2 * i + 1);
            #80 strobe_true = 1'b0;
            strobe_comp = 1'b1;
            #80;
        end
        // long postamble so the release edge lands after the last word
        #320 strobe_true = 1'b1;
        strobe_comp = 1'b0;
        busy = 1'b0;
    endtask
endmodule
`default_nettype wire

//--- verif/test_dsc_capture.sv
// self-checking bench for the read strobe capture block
// assumes a 25 MHz pclk and the memory model on the pins
`timescale 1ns/1ns
`default_nettype none
`include "dsc_defines.svh"
module test_dsc_capture;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        strobe_true, strobe_comp, read_arm, rd_valid, rd_ready;
    logic        capture_clock_polarity, out_gearing_en, err;
    logic        gear_top, pol_bot;
    logic [1:0]  capture_latency_select;
    logic [9:0]  dq_in;
    logic [11:0] paddr;
    logic [19:0] rd_data;
    logic [23:0] eq_setting;
    logic [31:0] pwdata, prdata, rdat;
    int          fail_count = 0;
    int          checks = 0;

    dsc_capture #(.EDGE(0), .DEPTH(2)) dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .strobe_true, .strobe_comp, .dq_in,
        .read_arm, .rd_data, .rd_valid, .rd_ready, .capture_clock_polarity,
        .capture_latency_select, .eq_setting, .out_gearing_en);

    dsc_mem_model mem (.strobe_true, .strobe_comp, .dq_in);

    // top and bottom edge copies share every input with dut
    dsc_capture #(.EDGE(2), .DEPTH(2)) dut_top (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata(), .pready(), .pslverr(), .strobe_true, .strobe_comp,
        .dq_in, .read_arm, .rd_data(), .rd_valid(), .rd_ready,
        .capture_clock_polarity(), .capture_latency_select(),
        .eq_setting(), .out_gearing_en(gear_top));
    dsc_capture #(.EDGE(3), .DEPTH(2)) dut_bot (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata(), .pready(), .pslverr(), .strobe_true, .strobe_comp,
        .dq_in, .read_arm, .rd_data(), .rd_valid(), .rd_ready,
        .capture_clock_polarity(pol_bot), .capture_latency_select(),
        .eq_setting(), .out_gearing_en());

    // system clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic conclude();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value at %0t: got %h exp %h", $time, g, e);
        end
    endtask

    // one apb transfer; the answer is taken at the rising edge that sees
    // pready, then the bench waits a half cycle so outputs are settled
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        logic done;
        done = 1'b0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (int i = 0; i < 16 && !done; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) begin
                done = 1'b1;
                rdat = prdata;
                err = pslverr;
            end
        end
        if (!done) begin
            fail_count++;
            conclude();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask

    task automatic arm();
        @(posedge pclk);
        read_arm <= 1'b1;
        @(posedge pclk);
        read_arm <= 1'b0;
    endtask

    // accept n words, each {falling beat, rising beat}
    task automatic take(input int n, input logic [9:0] base);
        int g;
        g = 0;
        for (int i = 0; i < 2000 && g < n; i++) begin
            @(negedge pclk);
            if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
                chk(rd_data, {base + 10'(2 * g + 1), base + 10'(2 * g)});
                g++;
            end
        end
        if (g < n) begin
            fail_count++;
            conclude();
        end
    endtask

    task automatic s_reset();
        rd(`DSC_OFF_CTRL, 32'h0);
        rd(`DSC_OFF_STATUS, 32'h0);
        rd(`DSC_OFF_EQ, 32'h0);
        rd(`DSC_OFF_BURST, 32'h4);
        chk(eq_setting, 24'h0);
        chk(capture_clock_polarity, 1'b0);
        chk(capture_latency_select, 2'h0);
        chk(out_gearing_en, 1'b0);
    endtask

    task automatic s_regs();
        wr(`DSC_OFF_EQ, 32'hE41B9C);
        chk(eq_setting, 24'hE41B9C);
        rd(`DSC_OFF_EQ, 32'hE41B9C);
        wr(`DSC_OFF_CTRL, 32'h62);
        chk(eq_setting, 24'h201310);
        chk(capture_latency_select, 2'h2);
        chk(out_gearing_en, 1'b1);
        chk(gear_top, 1'b0);
        // an unmapped write must be refused and leave control alone
        apb(1'b1, 12'h010, 32'hFF);
        chk(err, 1'b1);
        apb(1'b0, 12'h010, 32'h0);
        chk({err, rdat}, {1'b1, 32'h0});
        rd(`DSC_OFF_CTRL, 32'h62);
    endtask

    task automatic s_reads();
        wr(`DSC_OFF_BURST, 32'h4);
        wr(`DSC_OFF_CTRL, 32'h0D);
        arm();
        fork
            mem.burst(4, 10'h100, 0);
            take(4, 10'h100);
        join
        @(negedge pclk);
        chk(capture_clock_polarity, 1'b1);
        chk(pol_bot, 1'b0);
        rd(`DSC_OFF_STATUS, 32'h104);
        // new override only lands at the next read's first rise
        wr(`DSC_OFF_CTRL, 32'h07);
        chk(capture_clock_polarity, 1'b1);
        wr(`DSC_OFF_BURST, 32'h1);
        arm();
        fork
            mem.burst(1, 10'h2A0, 400);
            take(1, 10'h2A0);
        join
        @(negedge pclk);
        chk(capture_clock_polarity, 1'b0);
        rd(`DSC_OFF_STATUS, 32'h200);
    endtask

    // receiver stalls: two words kept, the rest refused and flagged
    task automatic s_stall();
        wr(`DSC_OFF_CTRL, 32'h21);
        wr(`DSC_OFF_BURST, 32'h4);
        chk(capture_latency_select, 2'h2);
        @(posedge pclk);
        rd_ready <= 1'b0;
        arm();
        mem.burst(4, 10'h300, 0);
        @(negedge pclk);
        chk(rd_valid, 1'b1);
        apb(1'b0, `DSC_OFF_STATUS, 32'h0);
        chk({rdat[15:8], rdat[3]}, {8'h03, 1'b1});
        @(posedge pclk);
        rd_ready <= 1'b1;
        take(2, 10'h300);
        @(negedge pclk);
        chk(rd_valid, 1'b0);
        wr(`DSC_OFF_STATUS, 32'h8);
        apb(1'b0, `DSC_OFF_STATUS, 32'h0);
        chk(rdat[3], 1'b0);
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        read_arm = 1'b0;
        rd_ready = 1'b1;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        s_reset();
        s_regs();
        s_reads();
        s_stall();
        conclude();
    end
endmodule
`default_nettype wire
